// File: cbz_defines.vh
// opcodes, field positions and cycle counts for the conditional branch unit
`ifndef CBZ_DEFINES_VH
`define CBZ_DEFINES_VH
`define CBZ_OP_HI 15
`define CBZ_OP_LO 7
`define CBZ_OP_NONZERO 9'h1eb
`define CBZ_OP_OVERFLOW 9'h1e1
`define CBZ_OP_ZERO 9'h1ed
`define CBZ_IND_BIT 7
`define CBZ_NARP_EN_BIT 3
`define CBZ_NARP_HI 2
`define CBZ_NARP_LO 0
`define CBZ_MOD_HI 6
`define CBZ_MOD_LO 4
`define CBZ_REGION_RAM 2'h0
`define CBZ_REGION_ROM 2'h1
`define CBZ_REGION_EXT 2'h2
`define CBZ_BASE_SHORT 4'h2
`define CBZ_BASE_LONG 4'h3
`define CBZ_PC_STEP 16'h0002
`define CBZ_AR_STEP 16'h0001
`endif

// File: cbz_cycle_calc.v
// cycle count of a conditional branch from fetch places and outcome
`timescale 1ns/1ps
`include "cbz_defines.vh"
module cbz_cycle_calc (
   // outcome and placement
   input wire taken_i,
   input wire prog_ext_i,
   input wire [1:0] dest_region_i,
   input wire [3:0] wait_p_i,
   // result
   output reg [7:0] cycles_o
);
   wire [7:0] p8;
   wire [7:0] base_s;
   wire [7:0] base_l;
   assign p8 = {4'h0, wait_p_i};
   assign base_s = {4'h0, `CBZ_BASE_SHORT};
   assign base_l = {4'h0, `CBZ_BASE_LONG};
   always @* begin
      if (!taken_i) begin
         cycles_o = prog_ext_i ? (base_s + {p8[6:0], 1'b0}) : base_s;
      end else if (dest_region_i == `CBZ_REGION_RAM) begin
         cycles_o = prog_ext_i ? (base_s + {p8[6:0], 1'b0}) : base_s;
      end else if (dest_region_i == `CBZ_REGION_ROM) begin
         cycles_o = prog_ext_i ? (base_l + {p8[6:0], 1'b0}) : base_l;
      end else begin
         cycles_o = prog_ext_i ? (base_l + {p8[6:0], 1'b0} + p8)
                               : (base_l + p8);
      end
   end
endmodule

// File: cbz_aux_update.v
// indirect update of the pointed auxiliary register and of its pointer
`timescale 1ns/1ps
`include "cbz_defines.vh"
module cbz_aux_update (
   // instruction field
   input wire [6:0] field_i,
   input wire ind_i,
   // current state
   input wire [2:0] ptr_i,
   input wire [15:0] aux_cur_i,
   input wire [15:0] aux0_i,
   // results
   output reg aux_we_o,
   output reg [15:0] aux_new_o,
   output reg ptr_we_o,
   output reg [2:0] ptr_new_o
);
   // mod field: 0 none, 1 dec, 2 inc, 5 sub index, 6 add index
   always @* begin
      aux_we_o = 1'b0;
      aux_new_o = aux_cur_i;
      ptr_we_o = 1'b0;
      ptr_new_o = ptr_i;
      if (ind_i) begin
         case (field_i[`CBZ_MOD_HI:`CBZ_MOD_LO])
            3'h1: begin
               aux_we_o = 1'b1;
               aux_new_o = aux_cur_i - `CBZ_AR_STEP;
            end
            3'h2: begin
               aux_we_o = 1'b1;
               aux_new_o = aux_cur_i + `CBZ_AR_STEP;
            end
            3'h5: begin
               aux_we_o = 1'b1;
               aux_new_o = aux_cur_i - aux0_i;
            end
            3'h6: begin
               aux_we_o = 1'b1;
               aux_new_o = aux_cur_i + aux0_i;
            end
            default: aux_we_o = 1'b0;
         endcase
         if (field_i[`CBZ_NARP_EN_BIT]) begin
            ptr_we_o = 1'b1;
            ptr_new_o = field_i[`CBZ_NARP_HI:`CBZ_NARP_LO];
         end
      end
   end
endmodule

// File: cbz_branch_unit.v
// Function
// - nonzero accumulator loads target, else pc plus two
// - overflow set: load target, clear flag
// - zero accumulator loads target, else pc plus two
// - two words; second is 16-bit target
// - new pointer 0..7 replaces after update
// - auxiliary update always applied, none if absent
// - taken to ram: 2 or 2+2p cycles
// - taken to rom: 3 or 3+2p cycles
// - taken to external: 3+p or 3+3p
// - not taken: 2 or 2+2p cycles
// - not executable under single-instruction repeat
`timescale 1ns/1ps
`include "cbz_defines.vh"
module cbz_branch_unit (
   // clock and control
   input wire clk_i,
   input wire srst_i,
   input wire ce_i,
   // instruction stream
   input wire instr_valid_i,
   input wire [15:0] instr_word_i,
   input wire [15:0] pc_i,
   input wire repeat_active_i,
   output wire instr_ready_o,
   // machine state in
   input wire [31:0] accumulator_reg_i,
   input wire overflow_flag_i,
   // placement of fetch and destination
   input wire prog_ext_i,
   input wire [1:0] dest_region_i,
   input wire [3:0] wait_p_i,
   // results
   output reg pc_we_o,
   output reg [15:0] pc_new_o,
   output reg taken_o,
   output reg overflow_clr_o,
   output reg illegal_repeat_o,
   output reg busy_o,
   output reg [7:0] cycles_o,
   output reg [2:0] aux_reg_pointer_o,
   output wire [15:0] aux_register_o
);
   localparam S_IDLE = 2'h0;
   localparam S_TARGET = 2'h1;
   localparam S_WAIT = 2'h2;

   localparam K_NONE = 2'h0;
   localparam K_NONZERO = 2'h1;
   localparam K_OVERFLOW = 2'h2;
   localparam K_ZERO = 2'h3;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [1:0] kind_reg;
   reg [6:0] field_reg;
   reg ind_reg;
   reg [15:0] pc_reg;
   reg [7:0] count_reg;
   reg [15:0] aux_mem [0:7];

   function [1:0] decode_kind;
      input [8:0] op;
      begin
         if (op == `CBZ_OP_NONZERO) begin
            decode_kind = K_NONZERO;
         end else if (op == `CBZ_OP_OVERFLOW) begin
            decode_kind = K_OVERFLOW;
         end else if (op == `CBZ_OP_ZERO) begin
            decode_kind = K_ZERO;
         end else begin
            decode_kind = K_NONE;
         end
      end
   endfunction

   wire [1:0] kind_dec;
   assign kind_dec = decode_kind(instr_word_i[`CBZ_OP_HI:`CBZ_OP_LO]);

   // branch condition, sampled when the target word arrives
   reg cond;
   always @* begin
      case (kind_reg)
         K_NONZERO: cond = (accumulator_reg_i != 32'h0);
         K_OVERFLOW: cond = overflow_flag_i;
         K_ZERO: cond = (accumulator_reg_i == 32'h0);
         default: cond = 1'b0;
      endcase
   end

   wire aux_we;
   wire [15:0] aux_new;
   wire ptr_we;
   wire [2:0] ptr_new;
   cbz_aux_update u_aux (
      .field_i(field_reg),
      .ind_i(ind_reg),
      .ptr_i(aux_reg_pointer_o),
      .aux_cur_i(aux_mem[aux_reg_pointer_o]),
      .aux0_i(aux_mem[0]),
      .aux_we_o(aux_we),
      .aux_new_o(aux_new),
      .ptr_we_o(ptr_we),
      .ptr_new_o(ptr_new)
   );

   wire [7:0] cyc;
   cbz_cycle_calc u_cyc (
      .taken_i(cond),
      .prog_ext_i(prog_ext_i),
      .dest_region_i(dest_region_i),
      .wait_p_i(wait_p_i),
      .cycles_o(cyc)
   );

   assign aux_register_o = aux_mem[aux_reg_pointer_o];
   // the wait state holds off the next instruction for the charged cycles beyond the two words
   assign instr_ready_o = (state_reg != S_WAIT);

   wire start;
   wire at_target;
   assign start = ce_i && instr_valid_i && (state_reg == S_IDLE)
                  && (kind_dec != K_NONE);
   assign at_target = ce_i && instr_valid_i && (state_reg == S_TARGET);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            if (start && !repeat_active_i) begin
               state_next = S_TARGET;
            end
         end
         S_TARGET: begin
            if (at_target) begin
               state_next = (cyc > {4'h0, `CBZ_BASE_SHORT}) ? S_WAIT
                                                            : S_IDLE;
            end
         end
         S_WAIT: begin
            if (ce_i && count_reg <= {4'h0, `CBZ_BASE_LONG}) begin
               state_next = S_IDLE;
            end
         end
         default: state_next = S_IDLE;
      endcase
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_aux
         always @(posedge clk_i) begin
            if (srst_i) begin
               aux_mem[gi] <= 16'h0000;
            end else if (at_target && aux_we
                         && aux_reg_pointer_o == gi) begin
               aux_mem[gi] <= aux_new;
            end
         end
      end
   endgenerate

   always @(posedge clk_i) begin
      if (srst_i) begin
         state_reg <= S_IDLE;
         kind_reg <= K_NONE;
         field_reg <= 7'h00;
         ind_reg <= 1'b0;
         pc_reg <= 16'h0000;
         count_reg <= 8'h00;
         pc_we_o <= 1'b0;
         pc_new_o <= 16'h0000;
         taken_o <= 1'b0;
         overflow_clr_o <= 1'b0;
         illegal_repeat_o <= 1'b0;
         busy_o <= 1'b0;
         cycles_o <= 8'h00;
         aux_reg_pointer_o <= 3'h0;
      end else if (ce_i) begin
         state_reg <= state_next;
         pc_we_o <= 1'b0;
         overflow_clr_o <= 1'b0;
         illegal_repeat_o <= 1'b0;
         busy_o <= (state_next != S_IDLE);
         if (state_reg == S_WAIT) begin
            count_reg <= count_reg - 8'h01;
         end
         if (start && repeat_active_i) begin
            // refused rather than repeated
            illegal_repeat_o <= 1'b1;
         end else if (start) begin
            kind_reg <= kind_dec;
            field_reg <= instr_word_i[6:0];
            ind_reg <= instr_word_i[`CBZ_IND_BIT];
            pc_reg <= pc_i;
         end
         if (at_target) begin
            pc_we_o <= 1'b1;
            taken_o <= cond;
            cycles_o <= cyc;
            count_reg <= cyc;
            if (cond) begin
               pc_new_o <= instr_word_i;
            end else begin
               pc_new_o <= pc_reg + `CBZ_PC_STEP;
            end
            if (cond && kind_reg == K_OVERFLOW) begin
               overflow_clr_o <= 1'b1;
            end
            if (ptr_we) begin
               aux_reg_pointer_o <= ptr_new;
            end
         end
      end
   end
endmodule

// File: cbz_branch_unit_asserts.sv
// concurrent checks on the ports of the conditional branch unit
`timescale 1ns/1ps
module cbz_branch_unit_asserts (
   input wire clk_i, input wire srst_i, input wire ce_i,
   input wire instr_valid_i, input wire [15:0] instr_word_i,
   input wire [15:0] pc_i, input wire repeat_active_i,
   input wire instr_ready_o, input wire [31:0] accumulator_reg_i,
   input wire overflow_flag_i, input wire prog_ext_i,
   input wire [1:0] dest_region_i, input wire [3:0] wait_p_i,
   input wire pc_we_o, input wire [15:0] pc_new_o, input wire taken_o,
   input wire overflow_clr_o, input wire illegal_repeat_o,
   input wire busy_o, input wire [7:0] cycles_o,
   input wire [2:0] aux_reg_pointer_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   reg [15:0] w_reg;
   reg [15:0] pc_reg;
   // first word is taken when idle, the target while busy and ready
   wire fw = ce_i && instr_valid_i && !busy_o && instr_ready_o;
   wire tgt = ce_i && instr_valid_i && busy_o && instr_ready_o;
   wire [8:0] op = w_reg[15:7];
   wire az = accumulator_reg_i == 32'h0;
   wire [15:0] nxt = pc_reg + 16'h0002;
   wire [7:0] c2 = prog_ext_i ? 8'h02 + {3'h0, wait_p_i, 1'h0} : 8'h02;
   always @(posedge clk_i) begin
      if (fw) begin
         w_reg <= instr_word_i;
         pc_reg <= pc_i;
      end
   end
   AST_TGT_ANSWER: assert property (tgt |=> pc_we_o ##1 !pc_we_o)
      else $error("pc load missing or longer than one cycle");
   AST_NZ_TAKEN: assert property (tgt && op == 9'h1eb && !az
      |=> taken_o && pc_new_o == $past(instr_word_i)) else $error("nz");
   AST_NZ_SKIP: assert property (tgt && op == 9'h1eb && az
      |=> !taken_o && pc_new_o == $past(nxt)) else $error("nz skip");
   AST_OV_TAKEN: assert property (tgt && op == 9'h1e1 && overflow_flag_i
      |=> taken_o && overflow_clr_o) else $error("ov taken");
   AST_OV_SKIP: assert property (tgt && op == 9'h1e1 && !overflow_flag_i
      |=> !overflow_clr_o && pc_new_o == $past(nxt)) else $error("ov skip");
   AST_Z_TAKEN: assert property (tgt && op == 9'h1ed && az
      |=> taken_o && pc_new_o == $past(instr_word_i)) else $error("z");
   AST_REPEAT: assert property (fw && repeat_active_i &&
      (instr_word_i[15:7] inside {9'h1eb, 9'h1e1, 9'h1ed})
      |=> illegal_repeat_o && !busy_o) else $error("branch under repeat");
   AST_CYC_SKIP: assert property (pc_we_o && !taken_o |-> cycles_o == c2)
      else $error("not-taken cycle count");
   AST_CYC_RAM: assert property (pc_we_o && taken_o &&
      dest_region_i == 2'h0 |-> cycles_o == c2) else $error("ram cycles");
   AST_NO_AUX: assert property (tgt && w_reg[6:0] == 7'h00
      |=> $stable(aux_reg_pointer_o)) else $error("pointer moved");
   COV_TAKEN: cover property (pc_we_o && taken_o);
   COV_OV_CLR: cover property (overflow_clr_o);
   COV_REPEAT: cover property (illegal_repeat_o);
endmodule
bind cbz_branch_unit cbz_branch_unit_asserts u_chk (.*);

// File: cbz_branch_unit_tb.sv
// self-checking bench for the conditional branch unit
`timescale 1ns/1ps
module cbz_branch_unit_tb;
   reg clk_i, srst_i, instr_valid_i, repeat_active_i, overflow_flag_i;
   reg prog_ext_i, ce_i;
   reg [15:0] instr_word_i, pc_i;
   reg [31:0] accumulator_reg_i;
   reg [1:0] dest_region_i;
   reg [3:0] wait_p_i;
   wire instr_ready_o, pc_we_o, taken_o, overflow_clr_o, illegal_repeat_o;
   wire busy_o;
   wire [15:0] pc_new_o, aux_register_o;
   wire [7:0] cycles_o;
   wire [2:0] aux_reg_pointer_o;
   integer failures = 0;
   integer n_tests = 0;
   integer i, j;
   reg [8:0] ops [0:2];
   cbz_branch_unit u_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
      .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i),
      .pc_i(pc_i), .repeat_active_i(repeat_active_i),
      .instr_ready_o(instr_ready_o), .accumulator_reg_i(accumulator_reg_i),
      .overflow_flag_i(overflow_flag_i), .prog_ext_i(prog_ext_i),
      .dest_region_i(dest_region_i), .wait_p_i(wait_p_i),
      .pc_we_o(pc_we_o), .pc_new_o(pc_new_o), .taken_o(taken_o),
      .overflow_clr_o(overflow_clr_o), .illegal_repeat_o(illegal_repeat_o),
      .busy_o(busy_o), .cycles_o(cycles_o),
      .aux_reg_pointer_o(aux_reg_pointer_o), .aux_register_o(aux_register_o));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task end_sim;
      if (failures == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one whole branch: opcode word, target 16'hffff, then the verdict
   task br(input [8:0] op, input [6:0] fld, input [31:0] acc, input ov,
         input ext, input [1:0] rg, input [3:0] p);
      reg t;
      reg [7:0] cy;
      integer k;
      t = op == 9'h1eb ? acc != 0 : op == 9'h1e1 ? ov : acc == 0;
      cy = (!t || rg == 2'h0) ? 8'h02 : 8'h03;
      if (ext)
         cy = cy + p * ((t && rg >= 2'h2) ? 3 : 2);
      else if (t && rg >= 2'h2)
         cy = cy + p;
      @(negedge clk_i);
      instr_valid_i = 1'b1;
      instr_word_i = {op, fld};
      pc_i = 16'h1230;
      accumulator_reg_i = acc;
      overflow_flag_i = ov;
      prog_ext_i = ext;
      dest_region_i = rg;
      wait_p_i = p;
      @(negedge clk_i);
      instr_word_i = 16'hffff;
      @(negedge clk_i);
      instr_valid_i = 1'b0;
      chk(pc_we_o, 1);
      chk(pc_new_o, t ? 16'hffff : 16'h1232);
      chk(taken_o, t);
      chk(overflow_clr_o, op == 9'h1e1 && ov);
      chk(cycles_o, cy);
      chk(instr_ready_o, cy <= 8'h02);
      for (k = 0; k < 60 && (busy_o || !instr_ready_o); k = k + 1)
         @(negedge clk_i);
      if (k == 60) begin
         failures = failures + 1;
         end_sim;
      end
      // the two words cover two cycles, the rest is held off
      chk(k, cy - 8'h02);
   endtask
   task t_cond;
      for (i = 0; i < 3; i = i + 1)
         for (j = 0; j < 2; j = j + 1)
            br(ops[i], 7'h00, j ? 32'h0 : 32'h80000000, j[0], 0, 0, 0);
   endtask
   task t_cycles;
      for (i = 0; i < 4; i = i + 1)
         for (j = 0; j < 2; j = j + 1)
            br(9'h1ed, 7'h00, 0, 0, j[0], i[1:0], 4'h5);
      br(9'h1eb, 7'h00, 0, 0, 1, 2'h2, 4'hf);
   endtask
   // clock enable low between the words: the target must still be awaited
   task t_ce;
      @(negedge clk_i);
      instr_valid_i = 1'b1;
      instr_word_i = {9'h1eb, 7'h00};
      accumulator_reg_i = 32'h1;
      prog_ext_i = 1'b0;
      dest_region_i = 2'h0;
      @(negedge clk_i);
      instr_word_i = 16'h4321;
      ce_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk(pc_we_o, 0);
      chk(busy_o, 1);
      ce_i = 1'b1;
      @(negedge clk_i);
      instr_valid_i = 1'b0;
      chk(pc_we_o, 1);
      chk(pc_new_o, 16'h4321);
   endtask
   task t_repeat;
      @(negedge clk_i);
      instr_valid_i = 1'b1;
      instr_word_i = {9'h1ef, 7'h00};
      @(negedge clk_i);
      chk(busy_o, 0);
      repeat_active_i = 1'b1;
      instr_word_i = {9'h1e1, 7'h00};
      @(negedge clk_i);
      instr_valid_i = 1'b0;
      repeat_active_i = 1'b0;
      chk(illegal_repeat_o, 1);
      chk(busy_o, 0);
   endtask
   task t_aux;
      chk(aux_reg_pointer_o, 0);
      br(9'h1ed, 7'h0d, 0, 0, 0, 0, 0);
      chk(aux_reg_pointer_o, 5);
      br(9'h1eb, 7'h20, 0, 0, 0, 0, 0);
      chk(aux_register_o, 1);
      br(9'h1e1, 7'h00, 0, 1, 0, 0, 0);
      chk(aux_reg_pointer_o, 5);
      chk(aux_register_o, 1);
      br(9'h1ed, 7'h0f, 1, 0, 0, 0, 0);
      chk(aux_reg_pointer_o, 7);
   endtask
   initial begin
      ops[0] = 9'h1eb;
      ops[1] = 9'h1e1;
      ops[2] = 9'h1ed;
      srst_i = 1'b1;
      ce_i = 1'b1;
      instr_valid_i = 1'b0;
      repeat_active_i = 1'b0;
      overflow_flag_i = 1'b0;
      prog_ext_i = 1'b0;
      instr_word_i = 16'h0000;
      pc_i = 16'h0000;
      accumulator_reg_i = 32'h0;
      dest_region_i = 2'h0;
      wait_p_i = 4'h0;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      srst_i = 1'b0;
      t_aux;
      t_cond;
      t_cycles;
      t_ce;
      t_repeat;
      // let the checker see the answer to the refused word
      repeat (2) @(negedge clk_i);
      end_sim;
   end
endmodule
